// file: logic/bdio_pkg.sv
package bdio_pkg;
	// printed offsets are not all multiples of four: they are indices, byte address = 4 * index
	localparam logic [15:0] CPU_PORT_A_DATA_IDX = 16'h8000;
	localparam logic [15:0] CPU_PORT_D_DATA_IDX = 16'h8008;
	localparam logic [15:0] CPU_PORT_E_INPUT_IDX = 16'h800A;
	localparam logic [15:0] ADAPTER_PORT_A_DATA_IDX = 16'h8080;
	localparam logic [15:0] ADAPTER_PORT_B_DATA_IDX = 16'h8081;
	localparam logic [15:0] ADAPTER_PORT_C_DATA_IDX = 16'h8082;
	// registers with no printed offset
	localparam logic [15:0] PORT_A_DIRECTION_REG_IDX = 16'h8001;
	localparam logic [15:0] PORT_D_DIRECTION_REG_IDX = 16'h8009;
	localparam logic [15:0] ADAPTER_CONFIG_IDX = 16'h8083;
	localparam logic [15:0] SERVICE_CTRL_IDX = 16'h8010;
	// adapter config field positions (1 = output)
	localparam int CFG_PA_OUT = 0;
	localparam int CFG_PB_OUT = 1;
	localparam int CFG_PCL_OUT = 2;
	localparam int CFG_PCH_OUT = 3;
	// reset: port a in, port b out, both port c halves in
	localparam logic [3:0] ADAPTER_CONFIG_RST = 4'h2;
	// service control bits (1 = service in use, pins committed)
	localparam int SVC_RS485 = 0;
	localparam int SVC_ADC8 = 1;
	localparam int SVC_SERIAL2 = 2;
	localparam int SVC_SPI = 3;
	localparam int SVC_ADC12 = 4;
	localparam int SVC_EXPIO = 5;
	localparam logic [5:0] SERVICE_CTRL_RST = 6'h0F;
	// pins committed to services, and the bonded-out port d lines
	localparam logic [7:0] CPU_A_SERIAL2_MASK = 8'h18;
	localparam logic [7:0] CPU_D_SPI_MASK = 8'h3C;
	localparam logic [7:0] CPU_D_AVAIL_MASK = 8'h3C;
	localparam logic [7:0] ADAPTER_C_RS485_MASK = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : bdio_pkg

// file: logic/bdio_pin_cell.sv
`timescale 1ns/1ps
// one 8-bit port: latched data, direction mask, pin drive and read mux
module bdio_pin_cell #(
	parameter int WIDTH = 8
) (
	// latched output data and per-bit direction (1 = output)
	input wire logic [WIDTH-1:0] data,
	input wire logic [WIDTH-1:0] dir,
	// pins
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out,
	output logic [WIDTH-1:0] pin_oe_n,
	// value a read returns
	output logic [WIDTH-1:0] rd_val
);
	always_comb begin
		// low and high drive from the latch
		pin_out = data;
		// input lines keep their latch but stay undriven
		pin_oe_n = ~dir;
		// inputs read their pin, outputs read back the latch
		rd_val = (dir & data) | (~dir & pin_in);
	end
endmodule : bdio_pin_cell

// file: logic/bdio_top.sv
`timescale 1ns/1ps
module bdio_top (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [17:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [17:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// processor port a pins
	input wire logic [7:0] cpu_a_in,
	output logic [7:0] cpu_a_out,
	output logic [7:0] cpu_a_oe_n,
	// processor port d pins (only 2-5 bonded out)
	input wire logic [7:0] cpu_d_in,
	output logic [7:0] cpu_d_out,
	output logic [7:0] cpu_d_oe_n,
	// processor input port pins
	input wire logic [7:0] cpu_e_in,
	// adapter port pins
	input wire logic [7:0] adp_a_in,
	output logic [7:0] adp_a_out,
	output logic [7:0] adp_a_oe_n,
	input wire logic [7:0] adp_b_in,
	output logic [7:0] adp_b_out,
	output logic [7:0] adp_b_oe_n,
	input wire logic [7:0] adp_c_in,
	output logic [7:0] adp_c_out,
	output logic [7:0] adp_c_oe_n,
	// service ownership: high while the service owns its pins
	output logic svc_adc8_analog,
	output logic svc_serial2_owns,
	output logic svc_spi_owns,
	output logic svc_rs485_owns,
	// fourth high-current driver, set through the onboard glue logic
	input wire logic hc4_request,
	output logic hc4_drive
);
	// all state in one struct
	typedef struct packed {
		logic [7:0] pa_data;
		logic [7:0] pa_dir;
		logic [7:0] pd_data;
		logic [7:0] pd_dir;
		logic [7:0] ap_a;
		logic [7:0] ap_b;
		logic [7:0] ap_c;
		logic [3:0] cfg;
		logic [5:0] svc;
		logic hc4;
		logic aw_held;
		logic [15:0] aw_idx;
		logic w_held;
		logic [31:0] w_data;
		logic w_strb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} bdio_state_t;

	bdio_state_t st;
	bdio_state_t next_st;
	// direction vectors fed to the pin cells
	logic [7:0] dir_pa, dir_pd, dir_aa, dir_ab, dir_ac;
	// readback from the pin cells
	logic [7:0] rd_pa, rd_pd, rd_aa, rd_ab, rd_ac;
	// write pending with both halves present
	logic do_write;
	logic [15:0] rd_idx;

	// byte address to register index
	function automatic logic [15:0] bdio_idx(input logic [17:0] addr);
		bdio_idx = addr[17:2];
	endfunction : bdio_idx

	// does an index name a mapped register
	function automatic logic bdio_mapped(input logic [15:0] idx);
		if (idx == bdio_pkg::CPU_PORT_A_DATA_IDX) bdio_mapped = 1'b1;
		else if (idx == bdio_pkg::PORT_A_DIRECTION_REG_IDX) bdio_mapped = 1'b1;
		else if (idx == bdio_pkg::CPU_PORT_D_DATA_IDX) bdio_mapped = 1'b1;
		else if (idx == bdio_pkg::PORT_D_DIRECTION_REG_IDX) bdio_mapped = 1'b1;
		else if (idx == bdio_pkg::CPU_PORT_E_INPUT_IDX) bdio_mapped = 1'b1;
		else if (idx == bdio_pkg::SERVICE_CTRL_IDX) bdio_mapped = 1'b1;
		else if (idx == bdio_pkg::ADAPTER_PORT_A_DATA_IDX) bdio_mapped = 1'b1;
		else if (idx == bdio_pkg::ADAPTER_PORT_B_DATA_IDX) bdio_mapped = 1'b1;
		else if (idx == bdio_pkg::ADAPTER_PORT_C_DATA_IDX) bdio_mapped = 1'b1;
		else if (idx == bdio_pkg::ADAPTER_CONFIG_IDX) bdio_mapped = 1'b1;
		else bdio_mapped = 1'b0;
	endfunction : bdio_mapped

	// direction derivation
	always_comb begin
		dir_pa = st.pa_dir;
		// serial 2 lines follow the uart while it is in use
		if (st.svc[bdio_pkg::SVC_SERIAL2]) begin
			dir_pa = st.pa_dir & ~bdio_pkg::CPU_A_SERIAL2_MASK;
		end
		// only four lines of port d exist
		dir_pd = st.pd_dir & bdio_pkg::CPU_D_AVAIL_MASK;
		// spi keeps its pins while spi or its users are active
		if (svc_spi_owns) begin
			dir_pd = 8'h00;
		end
		// adapter ports a and b bytewise
		dir_aa = {8{st.cfg[bdio_pkg::CFG_PA_OUT]}};
		// port b all inputs only as a whole byte
		dir_ab = {8{st.cfg[bdio_pkg::CFG_PB_OUT]}};
		dir_ac = {{4{st.cfg[bdio_pkg::CFG_PCH_OUT]}}, {4{st.cfg[bdio_pkg::CFG_PCL_OUT]}}};
		// rs485 direction line is driven while rs485 is in use
		if (st.svc[bdio_pkg::SVC_RS485]) begin
			dir_ac = dir_ac | bdio_pkg::ADAPTER_C_RS485_MASK;
		end
	end

	// pin cells, one per bidirectional port
	bdio_pin_cell #(.WIDTH(8)) u_pa (.data(st.pa_data), .dir(dir_pa), .pin_in(cpu_a_in),
		.pin_out(cpu_a_out), .pin_oe_n(cpu_a_oe_n), .rd_val(rd_pa));
	bdio_pin_cell #(.WIDTH(8)) u_pd (.data(st.pd_data), .dir(dir_pd), .pin_in(cpu_d_in),
		.pin_out(cpu_d_out), .pin_oe_n(cpu_d_oe_n), .rd_val(rd_pd));
	bdio_pin_cell #(.WIDTH(8)) u_aa (.data(st.ap_a), .dir(dir_aa), .pin_in(adp_a_in),
		.pin_out(adp_a_out), .pin_oe_n(adp_a_oe_n), .rd_val(rd_aa));
	bdio_pin_cell #(.WIDTH(8)) u_ab (.data(st.ap_b), .dir(dir_ab), .pin_in(adp_b_in),
		.pin_out(adp_b_out), .pin_oe_n(adp_b_oe_n), .rd_val(rd_ab));
	bdio_pin_cell #(.WIDTH(8)) u_ac (.data(st.ap_c), .dir(dir_ac), .pin_in(adp_c_in),
		.pin_out(adp_c_out), .pin_oe_n(adp_c_oe_n), .rd_val(rd_ac));

	// service ownership outputs
	always_comb begin
		// input port is analog for the whole byte while the converter runs
		svc_adc8_analog = st.svc[bdio_pkg::SVC_ADC8];
		svc_serial2_owns = st.svc[bdio_pkg::SVC_SERIAL2];
		svc_spi_owns = st.svc[bdio_pkg::SVC_SPI] | st.svc[bdio_pkg::SVC_ADC12]
			| st.svc[bdio_pkg::SVC_EXPIO];
		svc_rs485_owns = st.svc[bdio_pkg::SVC_RS485];
		// fourth driver is not an adapter port bit
		hc4_drive = st.hc4;
	end

	// bus handshakes
	assign s_axi_awready = ~st.aw_held & ~st.bvalid;
	assign s_axi_wready = ~st.w_held & ~st.bvalid;
	assign s_axi_arready = ~st.rvalid;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	assign do_write = st.aw_held & st.w_held & ~st.bvalid;
	assign rd_idx = bdio_idx(s_axi_araddr);

	// next-state logic
	always_comb begin
		next_st = st;
		next_st.hc4 = hc4_request;
		// capture write address
		if (s_axi_awvalid && s_axi_awready) begin
			next_st.aw_held = 1'b1;
			next_st.aw_idx = bdio_idx(s_axi_awaddr);
		end
		// capture write data
		if (s_axi_wvalid && s_axi_wready) begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb0 = s_axi_wstrb[0];
		end
		// perform the write once both halves are held
		if (do_write) begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = bdio_mapped(st.aw_idx) ? bdio_pkg::RESP_OKAY
				: bdio_pkg::RESP_SLVERR;
			if (st.w_strb0) begin
				if (st.aw_idx == bdio_pkg::CPU_PORT_A_DATA_IDX) begin
					next_st.pa_data = st.w_data[7:0];
				end else if (st.aw_idx == bdio_pkg::PORT_A_DIRECTION_REG_IDX) begin
					next_st.pa_dir = st.w_data[7:0];
				end else if (st.aw_idx == bdio_pkg::CPU_PORT_D_DATA_IDX) begin
					next_st.pd_data = st.w_data[7:0] & bdio_pkg::CPU_D_AVAIL_MASK;
				end else if (st.aw_idx == bdio_pkg::PORT_D_DIRECTION_REG_IDX) begin
					next_st.pd_dir = st.w_data[7:0] & bdio_pkg::CPU_D_AVAIL_MASK;
				end else if (st.aw_idx == bdio_pkg::SERVICE_CTRL_IDX) begin
					// freeing a service returns its pins
					next_st.svc = st.w_data[5:0];
				end else if (st.aw_idx == bdio_pkg::ADAPTER_PORT_A_DATA_IDX) begin
					next_st.ap_a = st.w_data[7:0];
				end else if (st.aw_idx == bdio_pkg::ADAPTER_PORT_B_DATA_IDX) begin
					next_st.ap_b = st.w_data[7:0];
				end else if (st.aw_idx == bdio_pkg::ADAPTER_PORT_C_DATA_IDX) begin
					next_st.ap_c = st.w_data[7:0];
				end else if (st.aw_idx == bdio_pkg::ADAPTER_CONFIG_IDX) begin
					next_st.cfg = st.w_data[3:0];
					// any config write zeros port a and upper c
					next_st.ap_a = 8'h00;
					next_st.ap_c = {4'h0, st.ap_c[3:0]};
				end
			end
		end
		// response taken
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		// read: answer one cycle after the address is taken
		if (s_axi_arvalid && s_axi_arready) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = bdio_pkg::RESP_OKAY;
			next_st.rdata = 32'h0000_0000;
			// data registers read pin levels for inputs
			if (rd_idx == bdio_pkg::CPU_PORT_A_DATA_IDX) begin
				next_st.rdata[7:0] = rd_pa;
			end else if (rd_idx == bdio_pkg::PORT_A_DIRECTION_REG_IDX) begin
				next_st.rdata[7:0] = st.pa_dir;
			end else if (rd_idx == bdio_pkg::CPU_PORT_D_DATA_IDX) begin
				next_st.rdata[7:0] = rd_pd & bdio_pkg::CPU_D_AVAIL_MASK;
			end else if (rd_idx == bdio_pkg::PORT_D_DIRECTION_REG_IDX) begin
				next_st.rdata[7:0] = st.pd_dir;
			end else if (rd_idx == bdio_pkg::CPU_PORT_E_INPUT_IDX) begin
				// analog mode gives no digital value
				next_st.rdata[7:0] = st.svc[bdio_pkg::SVC_ADC8] ? 8'h00 : cpu_e_in;
			end else if (rd_idx == bdio_pkg::SERVICE_CTRL_IDX) begin
				next_st.rdata[5:0] = st.svc;
			end else if (rd_idx == bdio_pkg::ADAPTER_PORT_A_DATA_IDX) begin
				next_st.rdata[7:0] = rd_aa;
			end else if (rd_idx == bdio_pkg::ADAPTER_PORT_B_DATA_IDX) begin
				next_st.rdata[7:0] = rd_ab;
			end else if (rd_idx == bdio_pkg::ADAPTER_PORT_C_DATA_IDX) begin
				next_st.rdata[7:0] = rd_ac;
			end else if (rd_idx == bdio_pkg::ADAPTER_CONFIG_IDX) begin
				next_st.rdata[3:0] = st.cfg;
			end else begin
				next_st.rresp = bdio_pkg::RESP_SLVERR;
			end
		end else if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.cfg <= bdio_pkg::ADAPTER_CONFIG_RST;
			st.svc <= bdio_pkg::SERVICE_CTRL_RST;
		end else begin
			st <= next_st;
		end
	end

	property p_out_follows;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && st.w_strb0 && st.aw_idx == bdio_pkg::ADAPTER_PORT_B_DATA_IDX
			&& st.cfg[bdio_pkg::CFG_PB_OUT]) |=> (adp_b_out == $past(st.w_data[7:0])
			&& adp_b_oe_n == 8'h00);
	endproperty
	a_out_follows: assert property (p_out_follows) else $error("port b pin mismatch");
	property p_read_pin;
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && rd_idx == bdio_pkg::ADAPTER_PORT_A_DATA_IDX
			&& !st.cfg[bdio_pkg::CFG_PA_OUT]) |=> (s_axi_rvalid
			&& s_axi_rdata[7:0] == $past(adp_a_in));
	endproperty
	a_read_pin: assert property (p_read_pin) else $error("read not pin level");
	property p_cfg_clear;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && st.w_strb0 && st.aw_idx == bdio_pkg::ADAPTER_CONFIG_IDX)
			|=> (adp_a_out == 8'h00 && adp_c_out[7:4] == 4'h0);
	endproperty
	a_cfg_clear: assert property (p_cfg_clear) else $error("config write kept outputs");
	property p_in_undriven;
		@(posedge aclk) disable iff (!aresetn)
		!st.cfg[bdio_pkg::CFG_PA_OUT] |-> adp_a_oe_n == 8'hFF;
	endproperty
	a_in_undriven: assert property (p_in_undriven) else $error("input port driven");
	// unbonded port d lines never driven
	property p_pd_avail;
		@(posedge aclk) disable iff (!aresetn)
		(cpu_d_oe_n | bdio_pkg::CPU_D_AVAIL_MASK) == 8'hFF;
	endproperty
	a_pd_avail: assert property (p_pd_avail) else $error("unbonded line driven");
	// spi lines held while the adc12 spi user is active
	property p_spi_hold;
		@(posedge aclk) disable iff (!aresetn)
		st.svc[bdio_pkg::SVC_ADC12] |-> cpu_d_oe_n == 8'hFF;
	endproperty
	a_spi_hold: assert property (p_spi_hold) else $error("spi pins taken");
	property p_reset_cfg;
		@(posedge aclk) $rose(aresetn) |-> st.cfg == bdio_pkg::ADAPTER_CONFIG_RST;
	endproperty
	a_reset_cfg: assert property (p_reset_cfg) else $error("bad reset config");
	property p_dir_bit;
		@(posedge aclk) disable iff (!aresetn)
		!st.svc[bdio_pkg::SVC_SERIAL2] |-> cpu_a_oe_n == ~st.pa_dir;
	endproperty
	a_dir_bit: assert property (p_dir_bit) else $error("direction mismatch");
	property p_nibble;
		@(posedge aclk) disable iff (!aresetn)
		!st.svc[bdio_pkg::SVC_RS485] |-> adp_c_oe_n
			== ~{{4{st.cfg[bdio_pkg::CFG_PCH_OUT]}}, {4{st.cfg[bdio_pkg::CFG_PCL_OUT]}}};
	endproperty
	a_nibble: assert property (p_nibble) else $error("nibble direction wrong");
	c_write: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
	c_read: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);
	c_cfg: cover property (@(posedge aclk) disable iff (!aresetn)
		do_write && st.aw_idx == bdio_pkg::ADAPTER_CONFIG_IDX);
endmodule : bdio_top

// file: dv/bdio_pin_model.sv
`timescale 1ns/1ps
// outside world of one port: a switch on every line, a load that
// follows the device wherever the device drives the line
module bdio_pin_model (
	// switch levels set by the bench
	input wire logic [7:0] sw,
	// device side of the pins
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	// level seen back on the wire
	output logic [7:0] pin_in
);
	// driven lines follow the device, released lines the switch
	assign pin_in = (pin_oe_n & sw) | (~pin_oe_n & pin_out);
endmodule : bdio_pin_model

// file: dv/tb_board_digital_io_ports.sv
`timescale 1ns/1ps
module tb_board_digital_io_ports;
	// clock, reset and bus
	logic aclk, aresetn;
	logic [17:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	// pins
	logic [7:0] cpu_a_in, cpu_a_out, cpu_a_oe_n, cpu_d_in, cpu_d_out, cpu_d_oe_n, cpu_e_in;
	logic [7:0] adp_a_in, adp_a_out, adp_a_oe_n, adp_b_in, adp_b_out, adp_b_oe_n;
	logic [7:0] adp_c_in, adp_c_out, adp_c_oe_n;
	logic svc_adc8_analog, svc_serial2_owns, svc_spi_owns, svc_rs485_owns, hc4_request, hc4_drive;
	// switch levels and bookkeeping
	logic [7:0] sw_a, sw_d, sw_pa, sw_pb, sw_pc;
	int err_count, n_checks;

	// device under test
	bdio_top i_bdio_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_a_in, .cpu_a_out, .cpu_a_oe_n,
		.cpu_d_in, .cpu_d_out, .cpu_d_oe_n, .cpu_e_in, .adp_a_in, .adp_a_out, .adp_a_oe_n,
		.adp_b_in, .adp_b_out, .adp_b_oe_n, .adp_c_in, .adp_c_out, .adp_c_oe_n,
		.svc_adc8_analog, .svc_serial2_owns, .svc_spi_owns, .svc_rs485_owns,
		.hc4_request, .hc4_drive);

	// switches and loads on each bidirectional port
	bdio_pin_model i_bdio_pin_model_a (.sw(sw_a), .pin_out(cpu_a_out), .pin_oe_n(cpu_a_oe_n),
		.pin_in(cpu_a_in));
	bdio_pin_model i_bdio_pin_model_d (.sw(sw_d), .pin_out(cpu_d_out), .pin_oe_n(cpu_d_oe_n),
		.pin_in(cpu_d_in));
	bdio_pin_model i_bdio_pin_model_pa (.sw(sw_pa), .pin_out(adp_a_out), .pin_oe_n(adp_a_oe_n),
		.pin_in(adp_a_in));
	bdio_pin_model i_bdio_pin_model_pb (.sw(sw_pb), .pin_out(adp_b_out), .pin_oe_n(adp_b_oe_n),
		.pin_in(adp_b_in));
	bdio_pin_model i_bdio_pin_model_pc (.sw(sw_pc), .pin_out(adp_c_out), .pin_oe_n(adp_c_oe_n),
		.pin_in(adp_c_in));

	// 200 MHz clock
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// verdict and end of run
	task automatic summarize();
		if (err_count == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize

	// one comparison
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
			err_count++;
		end
	endtask : chk

	// a wait that ran out ends the run
	task automatic wait_ok(input logic done);
		if (done !== 1'b1) begin
			$display("[ERR] handshake expected 1 seen 0");
			err_count++;
			summarize();
		end
	endtask : wait_ok

	// service ownership flags packed for one compare
	function automatic logic [7:0] svc_flags();
		return {4'h0, svc_rs485_owns, svc_spi_owns, svc_serial2_owns, svc_adc8_analog};
	endfunction : svc_flags

	// bus write: ready sampled mid-cycle holds until the edge, since inputs move only on edges
	task automatic axi_wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic aw, w, ta, tw, b;
		logic [1:0] rsp;
		aw = 1'b1;
		w = 1'b1;
		b = 1'b0;
		rsp = 2'h3;
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 40 && !b; n++) begin
			@(negedge aclk);
			ta = aw & s_axi_awready;
			tw = w & s_axi_wready;
			b = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			aw = aw & ~ta;
			w = w & ~tw;
		end
		s_axi_bready <= 1'b0;
		wait_ok(b);
		chk("bresp", {6'h00, er}, {6'h00, rsp});
		@(negedge aclk);
	endtask : axi_wr

	// bus read with expected low byte and response
	task automatic axi_rd(input logic [15:0] idx, input logic [7:0] ed, input logic [1:0] er);
		logic ta, r;
		logic [7:0] d;
		logic [1:0] rsp;
		r = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 40 && !r; n++) begin
			@(negedge aclk);
			ta = s_axi_arvalid & s_axi_arready;
			r = s_axi_rvalid;
			d = s_axi_rdata[7:0];
			rsp = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		wait_ok(r);
		chk($sformatf("rdata %h", idx), ed, d);
		chk("rresp", {6'h00, er}, {6'h00, rsp});
		// leave the edge behind so callers compare settled outputs
		@(negedge aclk);
	endtask : axi_rd

	// directions and ownership straight out of reset
	task automatic t_reset();
		@(negedge aclk);
		chk("adp_a_oe_n", 8'hFF, adp_a_oe_n);
		chk("adp_b_oe_n", 8'h00, adp_b_oe_n);
		chk("adp_c_oe_n", 8'hEF, adp_c_oe_n);
		chk("svc", 8'h0F, svc_flags());
		chk("cpu_a_oe_n", 8'hFF, cpu_a_oe_n);
	endtask : t_reset

	// bitwise port a: latch while input, then drive the low nibble
	task automatic t_cpu_a();
		axi_wr(bdio_pkg::SERVICE_CTRL_IDX, 8'h00, bdio_pkg::RESP_OKAY);
		@(posedge aclk);
		sw_a <= 8'h3C;
		axi_wr(bdio_pkg::CPU_PORT_A_DATA_IDX, 8'hA5, bdio_pkg::RESP_OKAY);
		chk("cpu_a_oe_n", 8'hFF, cpu_a_oe_n);
		axi_rd(bdio_pkg::CPU_PORT_A_DATA_IDX, 8'h3C, bdio_pkg::RESP_OKAY);
		axi_wr(bdio_pkg::PORT_A_DIRECTION_REG_IDX, 8'h0F, bdio_pkg::RESP_OKAY);
		chk("cpu_a_oe_n", 8'hF0, cpu_a_oe_n);
		chk("cpu_a_in", 8'h35, cpu_a_in);
		axi_rd(bdio_pkg::CPU_PORT_A_DATA_IDX, 8'h35, bdio_pkg::RESP_OKAY);
		axi_rd(bdio_pkg::PORT_A_DIRECTION_REG_IDX, 8'h0F, bdio_pkg::RESP_OKAY);
		axi_wr(bdio_pkg::CPU_PORT_A_DATA_IDX, 8'h5A, bdio_pkg::RESP_OKAY);
		chk("cpu_a_in", 8'h3A, cpu_a_in);
	endtask : t_cpu_a

	// services claim and free their pins
	task automatic t_svc();
		axi_wr(bdio_pkg::PORT_A_DIRECTION_REG_IDX, 8'hFF, bdio_pkg::RESP_OKAY);
		axi_wr(bdio_pkg::PORT_D_DIRECTION_REG_IDX, 8'hFF, bdio_pkg::RESP_OKAY);
		axi_wr(bdio_pkg::CPU_PORT_D_DATA_IDX, 8'hFF, bdio_pkg::RESP_OKAY);
		chk("cpu_a_oe_n", 8'h00, cpu_a_oe_n);
		chk("cpu_d_oe_n", 8'hC3, cpu_d_oe_n);
		axi_rd(bdio_pkg::CPU_PORT_D_DATA_IDX, 8'h3C, bdio_pkg::RESP_OKAY);
		chk("svc", 8'h00, svc_flags());
		axi_wr(bdio_pkg::SERVICE_CTRL_IDX, 8'h0F, bdio_pkg::RESP_OKAY);
		chk("cpu_a_oe_n", 8'h18, cpu_a_oe_n);
		chk("cpu_d_oe_n", 8'hFF, cpu_d_oe_n);
		chk("adp_c_oe_n", 8'hEF, adp_c_oe_n);
		axi_wr(bdio_pkg::SERVICE_CTRL_IDX, 8'h10, bdio_pkg::RESP_OKAY);
		chk("cpu_d_oe_n", 8'hFF, cpu_d_oe_n);
		chk("svc", 8'h04, svc_flags());
		axi_wr(bdio_pkg::SERVICE_CTRL_IDX, 8'h20, bdio_pkg::RESP_OKAY);
		chk("cpu_d_oe_n", 8'hFF, cpu_d_oe_n);
		axi_wr(bdio_pkg::SERVICE_CTRL_IDX, 8'h00, bdio_pkg::RESP_OKAY);
		chk("adp_c_oe_n", 8'hFF, adp_c_oe_n);
	endtask : t_svc

	// input port in digital then analog mode
	task automatic t_port_e();
		@(posedge aclk);
		cpu_e_in <= 8'h96;
		axi_rd(bdio_pkg::CPU_PORT_E_INPUT_IDX, 8'h96, bdio_pkg::RESP_OKAY);
		axi_wr(bdio_pkg::SERVICE_CTRL_IDX, 8'h02, bdio_pkg::RESP_OKAY);
		chk("svc", 8'h01, svc_flags());
		axi_rd(bdio_pkg::CPU_PORT_E_INPUT_IDX, 8'h00, bdio_pkg::RESP_OKAY);
		axi_rd(bdio_pkg::SERVICE_CTRL_IDX, 8'h02, bdio_pkg::RESP_OKAY);
		axi_wr(bdio_pkg::SERVICE_CTRL_IDX, 8'h00, bdio_pkg::RESP_OKAY);
	endtask : t_port_e

	// adapter ports: bytewise and nibble directions, clearing config write
	task automatic t_adapter();
		@(posedge aclk);
		sw_pb <= 8'hC3;
		sw_pa <= 8'h69;
		axi_wr(bdio_pkg::ADAPTER_CONFIG_IDX, 8'h0B, bdio_pkg::RESP_OKAY);
		chk("adp_a_oe_n", 8'h00, adp_a_oe_n);
		chk("adp_c_oe_n", 8'h0F, adp_c_oe_n);
		axi_wr(bdio_pkg::ADAPTER_PORT_A_DATA_IDX, 8'h5A, bdio_pkg::RESP_OKAY);
		axi_wr(bdio_pkg::ADAPTER_PORT_B_DATA_IDX, 8'h81, bdio_pkg::RESP_OKAY);
		axi_wr(bdio_pkg::ADAPTER_PORT_C_DATA_IDX, 8'hF7, bdio_pkg::RESP_OKAY);
		chk("adp_a_in", 8'h5A, adp_a_in);
		chk("adp_b_in", 8'h81, adp_b_in);
		chk("adp_c_hi", 8'hF0, adp_c_in & 8'hF0);
		axi_wr(bdio_pkg::ADAPTER_CONFIG_IDX, 8'h0B, bdio_pkg::RESP_OKAY);
		chk("adp_a_in", 8'h00, adp_a_in);
		chk("adp_c_hi", 8'h00, adp_c_in & 8'hF0);
		chk("adp_b_in", 8'h81, adp_b_in);
		axi_wr(bdio_pkg::ADAPTER_CONFIG_IDX, 8'h04, bdio_pkg::RESP_OKAY);
		chk("adp_b_oe_n", 8'hFF, adp_b_oe_n);
		chk("adp_c_oe_n", 8'hF0, adp_c_oe_n);
		axi_rd(bdio_pkg::ADAPTER_PORT_B_DATA_IDX, 8'hC3, bdio_pkg::RESP_OKAY);
		axi_rd(bdio_pkg::ADAPTER_PORT_A_DATA_IDX, 8'h69, bdio_pkg::RESP_OKAY);
		axi_rd(bdio_pkg::ADAPTER_CONFIG_IDX, 8'h04, bdio_pkg::RESP_OKAY);
		// low byte strobe off: write answered but ignored
		@(posedge aclk);
		s_axi_wstrb <= 4'hE;
		axi_wr(bdio_pkg::ADAPTER_PORT_C_DATA_IDX, 8'h00, bdio_pkg::RESP_OKAY);
		chk("adp_c_lo", 8'h07, adp_c_in & 8'h0F);
		@(posedge aclk);
		s_axi_wstrb <= 4'hF;
		axi_rd(16'h8084, 8'h00, bdio_pkg::RESP_SLVERR);
		axi_wr(16'h8084, 8'h00, bdio_pkg::RESP_SLVERR);
	endtask : t_adapter

	// fourth driver follows its request one cycle later
	task automatic t_hc4();
		@(posedge aclk);
		hc4_request <= 1'b1;
		@(negedge aclk);
		chk("hc4_drive", 8'h00, {7'h00, hc4_drive});
		@(negedge aclk);
		chk("hc4_drive", 8'h01, {7'h00, hc4_drive});
	endtask : t_hc4

	// reset in mid-run restores adapter directions and services
	task automatic t_rst();
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk("adp_a_oe_n", 8'hFF, adp_a_oe_n);
		chk("adp_b_oe_n", 8'h00, adp_b_oe_n);
		chk("adp_c_oe_n", 8'hEF, adp_c_oe_n);
		chk("svc", 8'h0F, svc_flags());
	endtask : t_rst

	// main sequence
	initial begin
		err_count = 0;
		n_checks = 0;
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		{sw_a, sw_d, sw_pa, sw_pb, sw_pc, cpu_e_in} = '0;
		hc4_request = 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_cpu_a();
		t_svc();
		t_port_e();
		t_adapter();
		t_rst();
		t_hc4();
		summarize();
	end
endmodule : tb_board_digital_io_ports
